//--- pwr_wake_pkg.sv
// shared constants for the power and wake event block
package pwr_wake_pkg;
    // ==========================================================
    // register offsets (byte addresses of 16-bit registers)
    localparam logic [7:0] ADDR_POWER_EVENT_CONTROL = 8'hD4;
    localparam logic [7:0] ADDR_SLEEP_WAKE_TIMING = 8'hD6;
    localparam logic [7:0] ADDR_PHY_BLOCK_RESET_CTRL = 8'hD8;
    // ==========================================================
    // power_event_control field positions
    localparam int OUT_DELAY_BIT = 14;
    localparam int POLARITY_BIT = 12;
    localparam int EVT_EN_HI = 11;
    localparam int EVT_EN_LO = 8;
    localparam int AUTO_WAKE_BIT = 7;
    localparam int WAKE_NORMAL_BIT = 6;
    localparam int STATUS_HI = 5;
    localparam int STATUS_LO = 2;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;
    localparam int RESERVED_RW_BIT = 13;
    // wake event status codes
    localparam logic [3:0] EVT_NONE = 4'h0;
    localparam logic [3:0] EVT_ENERGY = 4'h1;
    localparam logic [3:0] EVT_LINK_UP = 4'h2;
    localparam logic [3:0] EVT_REMOTE = 4'h4;
    localparam logic [3:0] EVT_FRAME = 4'h8;
    // power modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ENERGY_DETECT = 2'h1;
    localparam logic [1:0] MODE_POWER_SAVING = 2'h3;
    // ==========================================================
    // sleep_wake_timing fields and reset values; phy reset bit position
    localparam int WAKE_TIME_HI = 15;
    localparam int WAKE_TIME_LO = 8;
    localparam int SLEEP_TIME_HI = 7;
    localparam int SLEEP_TIME_LO = 0;
    localparam logic [7:0] WAKE_TIME_RESET = 8'h08;
    localparam logic [7:0] SLEEP_TIME_RESET = 8'h0C;
    localparam int PHY_RESET_BIT = 0;
    // ==========================================================
    // timing: 25 MHz reference enable tick, 1 ms base tick
    localparam int REF_CLK_KHZ = 25000;
    localparam int CORE_CLK_KHZ = 200000;
    localparam int MS_PER_TICK = 1;
    localparam int CYCLES_PER_MS = CORE_CLK_KHZ / 1000 * 1000 / 1000;
    localparam int REF_PER_MS = REF_CLK_KHZ * MS_PER_TICK;
    localparam int WAKE_UNIT_MS = 16;
    localparam int SLEEP_UNIT_MS = 1000;
    localparam int PHY_RESET_CYCLES = 4;
    localparam logic [1:0] CORE_PER_REF = 2'(CORE_CLK_KHZ / REF_CLK_KHZ / 4);
    // state of the energy detect substate
    typedef enum logic [0:0] {ST_LOW_POWER, ST_NORMAL_POWER} ed_state_type;
endpackage

//--- unit_timer.sv
// unit-scaled interval timer that restarts whenever its condition drops
`timescale 1ns/10ps
`default_nettype none
module unit_timer #(
    parameter int UNIT_TICKS = 16
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // control
    input wire logic i_tick,
    input wire logic i_cond,
    input wire logic [7:0] i_units,
    // result
    output logic o_expired
);
    logic [15:0] sub_q;
    logic [7:0] unit_q;

    // count base ticks into units while the condition holds; any gap restarts
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sub_q <= 16'h0000;
            unit_q <= 8'h00;
            o_expired <= 1'b0;
        end else if (!i_cond) begin
            sub_q <= 16'h0000;
            unit_q <= 8'h00;
            o_expired <= 1'b0;
        end else if (i_tick && !o_expired) begin
            if (sub_q == 16'(UNIT_TICKS - 1)) begin
                sub_q <= 16'h0000;
                if (unit_q + 8'h01 >= i_units) begin
                    o_expired <= 1'b1;
                end else begin
                    unit_q <= unit_q + 8'h01;
                end
            end else begin
                sub_q <= sub_q + 16'h0001;
            end
        end
    end
endmodule // unit_timer
`default_nettype wire

//--- power_event_wake_control.sv
// power mode, energy detect sleep/wake and wake event output control
// Operation
// - delay bit holds output until core ready
// - delay bit only counts with auto wake
// - polarity bit selects output active level
// - per-event enables gate the wake output
// - auto wake leaves low power after energy
// - wake-to-normal bit returns mode to normal
// - status field one-hot codes per event type
// - energy and link events flag interrupt bits
// - status clears only power-up or write-one
// - clearing status deasserts the wake output
// - mode field selects normal, detect, saving
// - wake-up time in 16 ms units, reset 8
// - go-sleep time in 1 s units, reset 12
// - phy reset bit pulses then self clears
`timescale 1ns/10ps
`default_nettype none
module power_event_wake_control #(
    parameter int REF_TICKS_PER_MS = pwr_wake_pkg::REF_PER_MS
) (
    // clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_soft_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [1:0] i_reg_be,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    // wake event sources and clocks ready (pins or other domains)
    input wire logic i_energy,
    input wire logic i_link_up,
    input wire logic i_remote_wake,
    input wire logic i_wake_frame,
    input wire logic i_clocks_ready,
    // outputs
    output logic o_wake_event_output,
    output logic o_int_energy_set,
    output logic o_int_link_set,
    output logic o_low_power,
    output logic [1:0] o_power_mode,
    output logic o_phy_reset
);
    // ==========================================================
    // input synchronisers
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic energy_s, link_s, remote_s, frame_s, ready_s;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {i_clocks_ready, i_wake_frame, i_remote_wake, i_link_up, i_energy};
            sync2_q <= sync1_q;
        end
    end
    assign energy_s = sync2_q[0];
    assign link_s = sync2_q[1];
    assign remote_s = sync2_q[2];
    assign frame_s = sync2_q[3];
    assign ready_s = sync2_q[4];

    // ==========================================================
    // control registers
    logic out_delay_q, reserved_q, polarity_q, auto_wake_q, wake_normal_q;
    logic [3:0] evt_en_q;
    logic [1:0] mode_q;
    logic [7:0] wake_time_q, sleep_time_q;
    logic [3:0] status_q;
    logic sel_pec, sel_swt, sel_phy, wake_to_normal;
    assign sel_pec = i_reg_addr == pwr_wake_pkg::ADDR_POWER_EVENT_CONTROL;
    assign sel_swt = i_reg_addr == pwr_wake_pkg::ADDR_SLEEP_WAKE_TIMING;
    assign sel_phy = i_reg_addr == pwr_wake_pkg::ADDR_PHY_BLOCK_RESET_CTRL;

    // power_event_control writable fields; soft reset restores defaults
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_delay_q <= 1'b0;
            reserved_q <= 1'b0;
            polarity_q <= 1'b0;
            evt_en_q <= 4'h0;
            auto_wake_q <= 1'b0;
            wake_normal_q <= 1'b0;
            mode_q <= pwr_wake_pkg::MODE_NORMAL;
        end else if (i_soft_rst) begin
            out_delay_q <= 1'b0;
            reserved_q <= 1'b0;
            polarity_q <= 1'b0;
            evt_en_q <= 4'h0;
            auto_wake_q <= 1'b0;
            wake_normal_q <= 1'b0;
            mode_q <= pwr_wake_pkg::MODE_NORMAL;
        end else begin
            if (i_reg_wr && sel_pec && i_reg_be[1]) begin
                out_delay_q <= i_reg_wdata[pwr_wake_pkg::OUT_DELAY_BIT];
                reserved_q <= i_reg_wdata[pwr_wake_pkg::RESERVED_RW_BIT];
                polarity_q <= i_reg_wdata[pwr_wake_pkg::POLARITY_BIT];
                evt_en_q <= i_reg_wdata[pwr_wake_pkg::EVT_EN_HI:pwr_wake_pkg::EVT_EN_LO];
            end
            if (i_reg_wr && sel_pec && i_reg_be[0]) begin
                auto_wake_q <= i_reg_wdata[pwr_wake_pkg::AUTO_WAKE_BIT];
                wake_normal_q <= i_reg_wdata[pwr_wake_pkg::WAKE_NORMAL_BIT];
                mode_q <= i_reg_wdata[pwr_wake_pkg::MODE_HI:pwr_wake_pkg::MODE_LO];
            end else if (wake_to_normal) begin
                mode_q <= pwr_wake_pkg::MODE_NORMAL;
            end
        end
    end

    // sleep_wake_timing register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_time_q <= pwr_wake_pkg::WAKE_TIME_RESET;
            sleep_time_q <= pwr_wake_pkg::SLEEP_TIME_RESET;
        end else if (i_soft_rst) begin
            wake_time_q <= pwr_wake_pkg::WAKE_TIME_RESET;
            sleep_time_q <= pwr_wake_pkg::SLEEP_TIME_RESET;
        end else if (i_reg_wr && sel_swt) begin
            if (i_reg_be[1]) begin
                wake_time_q <= i_reg_wdata[pwr_wake_pkg::WAKE_TIME_HI:pwr_wake_pkg::WAKE_TIME_LO];
            end
            if (i_reg_be[0]) begin
                sleep_time_q <= i_reg_wdata[pwr_wake_pkg::SLEEP_TIME_HI:pwr_wake_pkg::SLEEP_TIME_LO];
            end
        end
    end

    // ==========================================================
    // 1 ms base tick from a divider on the core clock
    logic [17:0] div_q;
    logic ms_tick;
    localparam int DIV_CYCLES = REF_TICKS_PER_MS
        * (pwr_wake_pkg::CORE_CLK_KHZ / pwr_wake_pkg::REF_CLK_KHZ);
    assign ms_tick = div_q == 18'(DIV_CYCLES - 1);
    // divider counts core cycles: 8 core cycles per reference period
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            div_q <= 18'h00000;
        end else if (ms_tick) begin
            div_q <= 18'h00000;
        end else begin
            div_q <= div_q + 18'h00001;
        end
    end

    // ==========================================================
    // energy detect substates and timers
    pwr_wake_pkg::ed_state_type ed_q;
    logic in_ed, wake_done, sleep_done;
    assign in_ed = mode_q == pwr_wake_pkg::MODE_ENERGY_DETECT;

    unit_timer #(.UNIT_TICKS(pwr_wake_pkg::WAKE_UNIT_MS)) u_wake_timer (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_tick(ms_tick),
        .i_cond(in_ed && ed_q == pwr_wake_pkg::ST_LOW_POWER && energy_s),
        .i_units(wake_time_q),
        .o_expired(wake_done)
    );
    unit_timer #(.UNIT_TICKS(pwr_wake_pkg::SLEEP_UNIT_MS)) u_sleep_timer (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_tick(ms_tick),
        .i_cond(in_ed && ed_q == pwr_wake_pkg::ST_NORMAL_POWER && !energy_s),
        .i_units(sleep_time_q),
        .o_expired(sleep_done)
    );
    assign wake_to_normal = in_ed && wake_done && auto_wake_q && wake_normal_q;

    // low/normal power substate within energy detect mode
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ed_q <= pwr_wake_pkg::ST_NORMAL_POWER;
        end else if (!in_ed) begin
            ed_q <= pwr_wake_pkg::ST_NORMAL_POWER;
        end else begin
            unique case (ed_q)
                pwr_wake_pkg::ST_NORMAL_POWER: begin
                    if (sleep_done) begin
                        ed_q <= pwr_wake_pkg::ST_LOW_POWER;
                    end
                end
                pwr_wake_pkg::ST_LOW_POWER: begin
                    if (wake_done && auto_wake_q) begin
                        ed_q <= pwr_wake_pkg::ST_NORMAL_POWER;
                    end
                end
            endcase
        end
    end
    assign o_low_power = (in_ed && ed_q == pwr_wake_pkg::ST_LOW_POWER)
        || mode_q == pwr_wake_pkg::MODE_POWER_SAVING;
    assign o_power_mode = mode_q;

    // ==========================================================
    // wake event status: only power-up reset or write-one clears
    logic link_d1_q, remote_d1_q, frame_d1_q, energy_d1_q;
    logic [3:0] evt_now, clr_mask;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            energy_d1_q <= 1'b0;
            link_d1_q <= 1'b0;
            remote_d1_q <= 1'b0;
            frame_d1_q <= 1'b0;
        end else begin
            energy_d1_q <= energy_s;
            link_d1_q <= link_s;
            remote_d1_q <= remote_s;
            frame_d1_q <= frame_s;
        end
    end
    assign evt_now = ({4{energy_s && !energy_d1_q}} & pwr_wake_pkg::EVT_ENERGY)
        | ({4{link_s && !link_d1_q}} & pwr_wake_pkg::EVT_LINK_UP)
        | ({4{remote_s && !remote_d1_q}} & pwr_wake_pkg::EVT_REMOTE)
        | ({4{frame_s && !frame_d1_q}} & pwr_wake_pkg::EVT_FRAME);
    assign clr_mask = (i_reg_wr && sel_pec && i_reg_be[0])
        ? i_reg_wdata[pwr_wake_pkg::STATUS_HI:pwr_wake_pkg::STATUS_LO] : 4'h0;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            status_q <= pwr_wake_pkg::EVT_NONE;
        end else begin
            status_q <= (status_q & ~clr_mask) | evt_now;
        end
    end
    // interrupt status set pulses for energy and link events
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_energy_set <= 1'b0;
            o_int_link_set <= 1'b0;
        end else begin
            o_int_energy_set <= |(evt_now & pwr_wake_pkg::EVT_ENERGY);
            o_int_link_set <= |(evt_now & pwr_wake_pkg::EVT_LINK_UP);
        end
    end

    // ==========================================================
    // wake event output with enable, delay and polarity
    logic assert_req, hold_off;
    assign assert_req = |(status_q & evt_en_q);
    assign hold_off = out_delay_q && auto_wake_q && !ready_s;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake_event_output <= 1'b1;
        end else begin
            o_wake_event_output <= (assert_req && !hold_off) ~^ polarity_q;
        end
    end

    // ==========================================================
    // phy block reset pulse, self clearing
    logic [2:0] phy_cnt_q;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            phy_cnt_q <= 3'h0;
        end else if (i_reg_wr && sel_phy && i_reg_be[0] && i_reg_wdata[pwr_wake_pkg::PHY_RESET_BIT]) begin
            phy_cnt_q <= 3'(pwr_wake_pkg::PHY_RESET_CYCLES);
        end else if (phy_cnt_q != 3'h0) begin
            phy_cnt_q <= phy_cnt_q - 3'h1;
        end
    end
    assign o_phy_reset = phy_cnt_q != 3'h0;

    // ==========================================================
    // read data, registered; unmapped registers and bit 15 read zero, reserved bit 13 reads back
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            if (sel_pec) begin
                o_reg_rdata <= {1'b0, out_delay_q, reserved_q, polarity_q, evt_en_q,
                    auto_wake_q, wake_normal_q, status_q, mode_q};
            end else if (sel_swt) begin
                o_reg_rdata <= {wake_time_q, sleep_time_q};
            end else begin
                o_reg_rdata <= 16'h0000; // phy reset bit is write only
            end
        end
    end
endmodule // power_event_wake_control
`default_nettype wire

//--- pwr_wake_asserts.sv
// port checker for the power and wake event block
`timescale 1ns/10ps
`default_nettype none
module pwr_wake_asserts #(
    parameter int REF_TICKS_PER_MS = 1
) (
    // clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_soft_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [1:0] i_reg_be,
    input wire logic [15:0] i_reg_wdata,
    // events and outputs
    input wire logic i_energy,
    input wire logic i_link_up,
    input wire logic o_wake_event_output,
    input wire logic o_int_energy_set,
    input wire logic o_int_link_set,
    input wire logic o_low_power,
    input wire logic [1:0] o_power_mode,
    input wire logic o_phy_reset
);
    // ==========================================================
    // helpers
    logic wr_ctl;
    logic pol_q;
    assign wr_ctl = i_reg_wr && i_reg_addr == pwr_wake_pkg::ADDR_POWER_EVENT_CONTROL;
    // programmed output polarity, cleared by either reset
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pol_q <= 1'b0;
        end else if (i_soft_rst) begin
            pol_q <= 1'b0;
        end else if (wr_ctl && i_reg_be[1]) begin
            pol_q <= i_reg_wdata[12];
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // properties
    property p_phy_start;
        i_reg_wr && i_reg_addr == pwr_wake_pkg::ADDR_PHY_BLOCK_RESET_CTRL && i_reg_be[0]
            && i_reg_wdata[0] |-> ##[1:2] o_phy_reset;
    endproperty
    a_phy_start: assert property (p_phy_start) else $error("phy reset not raised");
    property p_phy_len;
        $rose(o_phy_reset) |-> o_phy_reset [*4] ##1 !o_phy_reset;
    endproperty
    a_phy_len: assert property (p_phy_len) else $error("phy reset width wrong");
    property p_mode_wr;
        wr_ctl && i_reg_be[0] && i_reg_wdata[1:0] != 2'h2 && !i_soft_rst
            |=> o_power_mode == $past(i_reg_wdata[1:0]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("power mode not taken");
    property p_int_energy;
        $rose(i_energy) |-> ##[2:6] o_int_energy_set;
    endproperty
    a_int_energy: assert property (p_int_energy) else $error("energy flag missing");
    property p_int_link;
        $rose(i_link_up) |-> ##[2:6] o_int_link_set;
    endproperty
    a_int_link: assert property (p_int_link) else $error("link flag missing");
    property p_clear_out;
        wr_ctl && i_reg_be[0] && i_reg_wdata[5:2] == 4'hF |-> ##[1:3] o_wake_event_output != pol_q;
    endproperty
    a_clear_out: assert property (p_clear_out) else $error("output not released");
    property p_low_mode;
        o_power_mode != pwr_wake_pkg::MODE_ENERGY_DETECT
            |-> o_low_power == (o_power_mode == pwr_wake_pkg::MODE_POWER_SAVING);
    endproperty
    a_low_mode: assert property (p_low_mode) else $error("low power outside detect");
    property p_auto_ret;
        $changed(o_power_mode) && !$past(wr_ctl) && !$past(wr_ctl, 2) && !$past(i_soft_rst)
            |-> $past(o_power_mode) == pwr_wake_pkg::MODE_ENERGY_DETECT
            && o_power_mode == pwr_wake_pkg::MODE_NORMAL;
    endproperty
    a_auto_ret: assert property (p_auto_ret) else $error("mode changed unprompted");
endmodule // pwr_wake_asserts
bind power_event_wake_control pwr_wake_asserts #(.REF_TICKS_PER_MS(REF_TICKS_PER_MS)) u_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_be(i_reg_be), .i_reg_wdata(i_reg_wdata), .i_energy(i_energy),
    .i_link_up(i_link_up), .o_wake_event_output(o_wake_event_output),
    .o_int_energy_set(o_int_energy_set), .o_int_link_set(o_int_link_set),
    .o_low_power(o_low_power), .o_power_mode(o_power_mode), .o_phy_reset(o_phy_reset)
);
`default_nettype wire

//--- host_bus_model.sv
// host processor model driving the register port
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    // clock
    input wire logic i_core_clk,
    // register port toward the block
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [1:0] o_reg_be,
    output logic [15:0] o_reg_wdata,
    input wire logic [15:0] i_reg_rdata
);
    // idle bus from time zero
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_be = 2'h3;
        o_reg_wdata = 16'h0000;
    end
    // one write of both lanes; zero timer fields and the spare mode are never sent
    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        if (addr == pwr_wake_pkg::ADDR_SLEEP_WAKE_TIMING && (data[15:8] == 8'h00 || data[7:0] == 8'h00)) return;
        if (addr == pwr_wake_pkg::ADDR_POWER_EVENT_CONTROL && data[1:0] == 2'h2) return;
        @(posedge i_core_clk);
        #1;
        o_reg_addr = addr;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_wdata = ~data; // released data shows no stale value
    endtask
    // one read; data is registered at the taking edge
    task automatic rd(input logic [7:0] addr, output logic [15:0] data);
        @(posedge i_core_clk);
        #1;
        o_reg_addr = addr;
        o_reg_rd = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_reg_rd = 1'b0;
        data = i_reg_rdata;
    endtask
endmodule // host_bus_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the power and wake event block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [7:0] A_CTL = pwr_wake_pkg::ADDR_POWER_EVENT_CONTROL;
    localparam logic [7:0] A_TIME = pwr_wake_pkg::ADDR_SLEEP_WAKE_TIMING;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_soft_rst = 1'b0;
    logic i_energy = 1'b0, i_link_up = 1'b0, i_remote_wake = 1'b0, i_wake_frame = 1'b0;
    logic i_clocks_ready = 1'b1;
    logic [7:0] i_reg_addr;
    logic i_reg_wr, i_reg_rd, o_wake_event_output, o_int_energy_set, o_int_link_set;
    logic [1:0] i_reg_be, o_power_mode;
    logic [15:0] i_reg_wdata, o_reg_rdata;
    logic o_low_power, o_phy_reset;
    int n_fail = 0;
    int tests_run = 0;
    int n_int = 0;
    // weighted count of interrupt set pulses: energy counts 1, link counts 16
    always @(negedge i_core_clk) begin
        n_int <= n_int + (o_int_energy_set ? 1 : 0) + (o_int_link_set ? 16 : 0);
    end
    // ==========================================================
    // clock, host and block
    always #2.5 i_core_clk = ~i_core_clk;
    host_bus_model host (.i_core_clk(i_core_clk), .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
        .o_reg_rd(i_reg_rd), .o_reg_be(i_reg_be), .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata));
    power_event_wake_control #(.REF_TICKS_PER_MS(1)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_soft_rst(i_soft_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_be(i_reg_be), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_energy(i_energy), .i_link_up(i_link_up), .i_remote_wake(i_remote_wake),
        .i_wake_frame(i_wake_frame), .i_clocks_ready(i_clocks_ready),
        .o_wake_event_output(o_wake_event_output), .o_int_energy_set(o_int_energy_set),
        .o_int_link_set(o_int_link_set), .o_low_power(o_low_power), .o_power_mode(o_power_mode),
        .o_phy_reset(o_phy_reset));
    // ==========================================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    // event pins as {frame, remote, link, energy}, held three cycles
    task automatic pulse(input logic [3:0] code);
        {i_wake_frame, i_remote_wake, i_link_up, i_energy} = code;
        cyc(3);
        {i_wake_frame, i_remote_wake, i_link_up, i_energy} = 4'h0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd_chk(A_CTL, 16'h0000);
        rd_chk(A_TIME, 16'h080C);
        rd_chk(8'hDA, 16'h0000);
        chk({15'h0, o_wake_event_output}, 16'h0001);
        for (int m = 0; m < 4; m++) begin
            if (m != 2) begin
                host.wr(A_CTL, 16'(m));
                cyc(1);
                chk({14'h0, o_power_mode}, 16'(m));
            end
        end
        $display("test reset and modes done");
    endtask
    task automatic t_events;
        logic [15:0] hi;
        int base;
        base = n_int;
        for (int k = 0; k < 4; k++) begin
            hi = 16'h1F00;
            host.wr(A_CTL, hi);
            pulse(4'h1 << k);
            cyc(8);
            rd_chk(A_CTL, hi | (16'h0004 << k));
            chk({15'h0, o_wake_event_output}, 16'h0001);
            host.wr(A_CTL, hi | 16'h003C);
            cyc(3);
            chk({15'h0, o_wake_event_output}, 16'h0000);
            hi = 16'h1F00 ^ (16'h0100 << k);
            host.wr(A_CTL, hi);
            pulse(4'h1 << k);
            cyc(8);
            chk({15'h0, o_wake_event_output}, 16'h0000);
            host.wr(A_CTL, hi | 16'h003C);
        end
        chk(16'(n_int - base), 16'h0022);
        $display("test wake events done");
    endtask
    task automatic t_resets;
        host.wr(A_TIME, 16'h0303);
        host.wr(A_CTL, 16'h1F00);
        pulse(4'h2);
        cyc(8);
        i_soft_rst = 1'b1;
        cyc(1);
        i_soft_rst = 1'b0;
        rd_chk(A_CTL, 16'h0008);
        rd_chk(A_TIME, 16'h080C);
        i_rst = 1'b1;
        cyc(2);
        i_rst = 1'b0;
        rd_chk(A_CTL, 16'h0000);
        $display("test resets done");
    endtask
    task automatic t_delay;
        i_clocks_ready = 1'b0;
        host.wr(A_CTL, 16'h5480);
        pulse(4'h4);
        cyc(8);
        chk({15'h0, o_wake_event_output}, 16'h0000);
        i_clocks_ready = 1'b1;
        cyc(8);
        chk({15'h0, o_wake_event_output}, 16'h0001);
        host.wr(A_CTL, 16'h54BC);
        i_clocks_ready = 1'b0;
        host.wr(A_CTL, 16'h5400);
        pulse(4'h4);
        cyc(8);
        chk({15'h0, o_wake_event_output}, 16'h0001);
        host.wr(A_CTL, 16'h543C);
        i_clocks_ready = 1'b1;
        $display("test output delay done");
    endtask
    task automatic t_energy;
        host.wr(A_TIME, 16'h0101);
        host.wr(A_CTL, 16'h003D);
        cyc(5000);
        pulse(4'h1);
        cyc(4000);
        chk({15'h0, o_low_power}, 16'h0000);
        cyc(5000);
        chk({15'h0, o_low_power}, 16'h0001);
        i_energy = 1'b1;
        cyc(300);
        chk({15'h0, o_low_power}, 16'h0001);
        host.wr(A_CTL, 16'h00BD);
        cyc(300);
        chk({14'h0, o_low_power, 1'b0}, 16'h0000);
        chk({14'h0, o_power_mode}, 16'h0001);
        i_energy = 1'b0;
        host.wr(A_CTL, 16'h00FD);
        cyc(9000);
        chk({15'h0, o_low_power}, 16'h0001);
        i_energy = 1'b1;
        cyc(300);
        chk({14'h0, o_power_mode}, 16'h0000);
        i_energy = 1'b0;
        host.wr(A_CTL, 16'h003C);
        $display("test energy detect done");
    endtask
    task automatic t_phy;
        int hi;
        hi = 0;
        host.wr(pwr_wake_pkg::ADDR_PHY_BLOCK_RESET_CTRL, 16'h0001);
        repeat (10) begin
            if (o_phy_reset === 1'b1) hi++;
            cyc(1);
        end
        chk(16'(hi), 16'h0004);
        rd_chk(pwr_wake_pkg::ADDR_PHY_BLOCK_RESET_CTRL, 16'h0000);
        $display("test phy reset done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        cyc(10);
        i_rst = 1'b0;
        t_reset();
        t_events();
        t_resets();
        t_delay();
        t_energy();
        t_phy();
        finish_test();
    end
    initial begin
        #250_000;
        n_fail++;
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
